// [verilog/dlr_top.sv]
// Defect list source: holds entries per surface and streams the list sector.
//
// Overview of operation
// - Primary list lives cylinder 1249 sector zero.
// - Backup copy served from cylinder 1241.
// - Each surface lists only its own defects.
// - Data field is exactly 256 bytes.
// - Entries are five consecutive bytes.
// - List ends with all-ones entry or sector end.
// - CRC register starts from zero.
// - Sync byte is accumulated into the CRC.
`timescale 1ns/10ps
module dlr_top (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Defect entry loading.
  input wire logic ld_clear,
  input wire logic ld_valid,
  output logic ld_ready,
  input wire logic [2:0] ld_head,
  input wire logic [39:0] ld_entry,
  // Sector read request.
  input wire logic rq_valid,
  output logic rq_ready,
  input wire logic [10:0] rq_cyl,
  input wire logic [2:0] rq_head,
  input wire logic [7:0] rq_sector,
  output logic rq_reject,
  // Byte stream to the controller.
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  // Status.
  output logic busy
);
  import dlr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  dlr_state_t state_r;
  dlr_mode_t mode_r;
  dlr_mode_t src_mode;
  logic [39:0] ent_data_r [DLR_STORE_DEPTH];
  logic [2:0] ent_head_r [DLR_STORE_DEPTH];
  logic [4:0] cnt_r;
  logic [2:0] head_r;
  logic [8:0] byte_cnt_r;
  logic [2:0] ebyte_r;
  logic [4:0] scan_r;
  logic [3:0] sel_r;
  logic [3:0] found_idx;
  logic found;
  logic [3:0] cur_idx;
  logic [7:0] push_byte;
  logic push_last;
  logic push;
  logic fifo_ready;
  logic crc_clr;
  logic crc_en;
  logic [15:0] crc;
  logic rq_hit;
  logic rq_take;
  logic ld_take;

  ////////////////////////////////////////////////////////////////////////////////
  // Entry store.

  // Entries can only be loaded while no list is being streamed.
  assign ld_ready = (state_r == DLR_ST_IDLE) && (cnt_r != DLR_STORE_FULL) && !ld_clear;
  assign ld_take = ld_valid && ld_ready;

  // Fill count; clearing empties all surfaces at once.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 5'h00;
    end else if (ld_clear && state_r == DLR_ST_IDLE) begin
      cnt_r <= 5'h00;
    end else if (ld_take) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // Each slot keeps its entry and the surface it belongs to.
  for (genvar g = 0; g < DLR_STORE_DEPTH; g++) begin : g_store
    always_ff @(posedge clock) begin
      if (ld_take && cnt_r == 5'(g)) begin
        ent_data_r[g] <= ld_entry;
        ent_head_r[g] <= ld_head;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request decode.

  // Only sector zero of the primary or backup cylinder holds the list.
  assign rq_hit = (rq_sector == DLR_LIST_SECTOR) &&
                  ((rq_cyl == DLR_PRIMARY_CYL) || (rq_cyl == DLR_BACKUP_CYL));
  assign rq_ready = (state_r == DLR_ST_IDLE);
  assign rq_take = rq_valid && rq_ready;
  assign busy = (state_r != DLR_ST_IDLE);

  // A request for any other location is answered with a reject pulse.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rq_reject <= 1'b0;
    end else begin
      rq_reject <= rq_take && !rq_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte source.

  // Find the next stored entry for the requested surface from the scan point.
  always_comb begin
    found = 1'b0;
    found_idx = 4'h0;
    for (int i = DLR_STORE_DEPTH - 1; i >= 0; i--) begin
      if (5'(i) >= scan_r && 5'(i) < cnt_r && ent_head_r[i] == head_r) begin
        found = 1'b1;
        found_idx = 4'(i);
      end
    end
  end

  // At an entry boundary pick entry, end marker or pad; a whole entry must fit.
  always_comb begin
    src_mode = mode_r;
    if (ebyte_r == 3'h0 && mode_r != DLR_M_PAD) begin
      if (byte_cnt_r > DLR_LAST_SLOT) begin
        src_mode = DLR_M_PAD;
      end else if (mode_r == DLR_M_ENT && !found) begin
        src_mode = DLR_M_MARK;
      end
    end
  end

  assign cur_idx = (ebyte_r == 3'h0) ? found_idx : sel_r;

  // Select the byte to push, most significant entry byte first.
  always_comb begin
    push_byte = DLR_PAD_BYTE;
    push_last = 1'b0;
    unique case (state_r)
      DLR_ST_SYNC: push_byte = DLR_SYNC_BYTE;
      DLR_ST_DATA: begin
        unique case (src_mode)
          DLR_M_ENT: push_byte = 8'(ent_data_r[cur_idx] >> {DLR_ENTRY_LAST - ebyte_r, 3'h0});
          DLR_M_MARK: push_byte = DLR_MARK_BYTE;
          default: push_byte = DLR_PAD_BYTE;
        endcase
      end
      DLR_ST_CRCH: push_byte = crc[15:8];
      DLR_ST_CRCL: begin
        push_byte = crc[7:0];
        push_last = 1'b1;
      end
      default: push_byte = DLR_PAD_BYTE;
    endcase
  end

  assign push = (state_r != DLR_ST_IDLE) && fifo_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Sync, fixed-length field, then the two check bytes.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= DLR_ST_IDLE;
    end else begin
      unique case (state_r)
        DLR_ST_IDLE: if (rq_take && rq_hit) state_r <= DLR_ST_SYNC;
        DLR_ST_SYNC: if (push) state_r <= DLR_ST_DATA;
        DLR_ST_DATA: if (push && byte_cnt_r == DLR_LAST_BYTE) state_r <= DLR_ST_CRCH;
        DLR_ST_CRCH: if (push) state_r <= DLR_ST_CRCL;
        DLR_ST_CRCL: if (push) state_r <= DLR_ST_IDLE;
        default: state_r <= DLR_ST_IDLE;
      endcase
    end
  end

  // Request surface is held for the whole sector.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      head_r <= 3'h0;
    end else if (rq_take) begin
      head_r <= rq_head;
    end
  end

  // Field byte counter and position inside the current five-byte entry.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      byte_cnt_r <= 9'h000;
      ebyte_r <= 3'h0;
    end else if (rq_take) begin
      byte_cnt_r <= 9'h000;
      ebyte_r <= 3'h0;
    end else if (push && state_r == DLR_ST_DATA) begin
      byte_cnt_r <= byte_cnt_r + 9'h001;
      ebyte_r <= (ebyte_r == DLR_ENTRY_LAST) ? 3'h0 : ebyte_r + 3'h1;
    end
  end

  // Scan pointer, chosen entry and list phase.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scan_r <= 5'h00;
      sel_r <= 4'h0;
      mode_r <= DLR_M_ENT;
    end else if (rq_take) begin
      scan_r <= 5'h00;
      mode_r <= DLR_M_ENT;
    end else if (push && state_r == DLR_ST_DATA) begin
      mode_r <= (src_mode == DLR_M_MARK && ebyte_r == DLR_ENTRY_LAST) ? DLR_M_PAD : src_mode;
      if (ebyte_r == 3'h0) begin
        sel_r <= found_idx;
        scan_r <= 5'(found_idx) + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // CRC and output buffer.

  // Seed on accept; sync and all field bytes are accumulated.
  assign crc_clr = rq_take;
  assign crc_en = push && (state_r == DLR_ST_SYNC || state_r == DLR_ST_DATA);

  dlr_crc16 u_crc (
    .clock(clock),
    .resetn(resetn),
    .clr(crc_clr),
    .en(crc_en),
    .din(push_byte),
    .crc(crc)
  );

  // The buffer stalls the sequencer when the controller stops draining.
  dlr_fifo #(
    .WIDTH(DLR_FIFO_WIDTH),
    .DEPTH(DLR_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({push_last, push_byte}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_last, out_data})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_start;
    @(posedge clock) disable iff (!resetn)
      rq_take && rq_hit |=> state_r == DLR_ST_SYNC;
  endproperty
  a_start: assert property (p_start) else $error("list request not started");

  property p_reject;
    @(posedge clock) disable iff (!resetn)
      rq_take && rq_cyl != DLR_PRIMARY_CYL && rq_cyl != DLR_BACKUP_CYL |=> rq_reject;
  endproperty
  a_reject: assert property (p_reject) else $error("bad cylinder not rejected");

  property p_len;
    @(posedge clock) disable iff (!resetn)
      $rose(state_r == DLR_ST_CRCH) |-> byte_cnt_r == DLR_FIELD_BYTES;
  endproperty
  a_len: assert property (p_len) else $error("field length wrong");

  property p_step;
    @(posedge clock) disable iff (!resetn)
      push && state_r == DLR_ST_DATA && ebyte_r == DLR_ENTRY_LAST |=> ebyte_r == 3'h0;
  endproperty
  a_step: assert property (p_step) else $error("entry step not five");

  property p_seed;
    @(posedge clock) disable iff (!resetn)
      $rose(state_r == DLR_ST_SYNC) |-> crc == DLR_CRC_SEED;
  endproperty
  a_seed: assert property (p_seed) else $error("crc not seeded");

  property p_sync;
    @(posedge clock) disable iff (!resetn)
      push && state_r == DLR_ST_SYNC |-> crc_en && push_byte == DLR_SYNC_BYTE;
  endproperty
  a_sync: assert property (p_sync) else $error("sync byte not in crc");

  property p_mark;
    @(posedge clock) disable iff (!resetn)
      push && state_r == DLR_ST_DATA && src_mode == DLR_M_MARK |-> push_byte == DLR_MARK_BYTE;
  endproperty
  a_mark: assert property (p_mark) else $error("end marker not all ones");

  property p_head;
    @(posedge clock) disable iff (!resetn)
      push && state_r == DLR_ST_DATA && src_mode == DLR_M_ENT |-> ent_head_r[cur_idx] == head_r;
  endproperty
  a_head: assert property (p_head) else $error("entry from other surface");

  property p_crch;
    @(posedge clock) disable iff (!resetn)
      push && state_r == DLR_ST_CRCH |=> state_r == DLR_ST_CRCL && $past(push_byte) == crc[15:8];
  endproperty
  a_crch: assert property (p_crch) else $error("crc high byte wrong");
endmodule : dlr_top

// [verilog/dlr_pkg.sv]
// Package of constants and types shared by the defect list source logic.
package dlr_pkg;
  localparam logic [10:0] DLR_PRIMARY_CYL = 11'h4E1;
  localparam logic [10:0] DLR_BACKUP_CYL = 11'h4D9;
  localparam logic [7:0] DLR_LIST_SECTOR = 8'h00;
  localparam logic [8:0] DLR_FIELD_BYTES = 9'h100;
  localparam logic [8:0] DLR_LAST_BYTE = 9'h0FF;
  localparam logic [8:0] DLR_LAST_SLOT = 9'h0FB;
  localparam logic [2:0] DLR_ENTRY_BYTES = 3'h5;
  localparam logic [2:0] DLR_ENTRY_LAST = 3'h4;
  localparam logic [15:0] DLR_CRC_POLY = 16'h1021;
  localparam logic [15:0] DLR_CRC_SEED = 16'h0000;
  localparam logic [7:0] DLR_SYNC_BYTE = 8'hA1;
  localparam logic [7:0] DLR_MARK_BYTE = 8'hFF;
  localparam logic [7:0] DLR_PAD_BYTE = 8'h00;
  localparam int DLR_STORE_DEPTH = 16;
  localparam logic [4:0] DLR_STORE_FULL = 5'h10;
  localparam int DLR_FIFO_DEPTH = 32;
  localparam int DLR_FIFO_WIDTH = 9;
  typedef enum logic [2:0] {
    DLR_ST_IDLE = 3'b000,
    DLR_ST_SYNC = 3'b001,
    DLR_ST_DATA = 3'b010,
    DLR_ST_CRCH = 3'b011,
    DLR_ST_CRCL = 3'b100
  } dlr_state_t;
  typedef enum logic [1:0] {
    DLR_M_ENT = 2'b00,
    DLR_M_MARK = 2'b01,
    DLR_M_PAD = 2'b10
  } dlr_mode_t;
endpackage : dlr_pkg

// [verilog/dlr_crc16.sv]
// Byte-wide CRC accumulator, most significant bit first.
`timescale 1ns/10ps
module dlr_crc16 (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Control.
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  // Result.
  output logic [15:0] crc
);
  import dlr_pkg::*;

  logic [15:0] crc_nxt;

  // Eight serial shift steps folded into one clock, first bit is bit 7.
  always_comb begin
    logic fb;
    crc_nxt = crc;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = crc_nxt[15] ^ din[i];
      crc_nxt = {crc_nxt[14:0], 1'b0} ^ (fb ? DLR_CRC_POLY : 16'h0000);
    end
  end

  // Clear loads the zero seed; enable takes one byte.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      crc <= 16'h0000;
    end else if (clr) begin
      crc <= DLR_CRC_SEED;
    end else if (en) begin
      crc <= crc_nxt;
    end
  end
endmodule : dlr_crc16

// [verilog/dlr_fifo.sv]
// First-in first-out buffer with valid and ready on both sides.
`timescale 1ns/10ps
module dlr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only at the write pointer.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointers and count move with each accepted word.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dlr_fifo

// [tb/dlr_ctl_model.sv]
// Controller-side reader model that drains and judges the defect list stream.
`timescale 1ns/10ps
module dlr_ctl_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Byte stream from the source.
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready,
  // Test control.
  input wire logic hold
);
  logic [7:0] mem [0:299];
  int n;
  int last_n;
  int frames;
  logic [15:0] crc_r;
  logic [7:0] hi_r;
  logic crc_ok;
  logic crc_err;

  // Folds one byte into the check value, one bit per shift, top bit first.
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : fold

  // Stalls at random, and throughout while hold is set.
  initial begin
    out_ready = 1'b0;
    forever begin
      @(negedge clock);
      out_ready = !hold && ($urandom_range(0, 3) != 0);
    end
  end

  // Captures bytes; entry positions stay raw byte counts from index, good to nine bits.
  // The list is judged by its check bytes, so repeated reads are not needed.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      n <= 0;
      frames <= 0;
      crc_r <= 16'h0000;
      crc_ok <= 1'b0;
      crc_err <= 1'b0;
    end else if (out_valid && out_ready) begin
      mem[n] <= out_data;
      n <= out_last ? 0 : n + 1;
      // Byte zero is the sync byte, so it enters the check value first.
      if (n <= 256) crc_r <= fold(crc_r, out_data);
      if (n == 257) hi_r <= out_data;
      if (out_last) begin
        last_n <= n + 1;
        frames <= frames + 1;
        crc_ok <= ({hi_r, out_data} === crc_r);
        crc_err <= ({hi_r, out_data} !== crc_r);
        crc_r <= 16'h0000;
      end
    end
  end
endmodule : dlr_ctl_model

// [tb/tb_top.sv]
// Self-checking testbench for the defect list source.
`timescale 1ns/10ps
module tb_top;
  import dlr_pkg::*;
  logic clock;
  logic resetn;
  logic ld_clear;
  logic ld_valid;
  logic ld_ready;
  logic [2:0] ld_head;
  logic [39:0] ld_entry;
  logic rq_valid;
  logic rq_ready;
  logic [10:0] rq_cyl;
  logic [2:0] rq_head;
  logic [7:0] rq_sector;
  logic rq_reject;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;
  logic out_last;
  logic busy;
  logic hold;
  int n_fail;
  int total_checks;
  int cyc;
  logic [2:0] q_head [$];
  logic [39:0] q_ent [$];
  logic [7:0] exp_f [0:255];
  logic [18:0] miss_tbl [0:3] = '{{11'h4E0, 8'h00}, {11'h4E1, 8'h01},
                                  {11'h4D9, 8'hFF}, {11'h000, 8'h00}};

  dlr_top dut (.clock(clock), .resetn(resetn), .ld_clear(ld_clear), .ld_valid(ld_valid),
    .ld_ready(ld_ready), .ld_head(ld_head), .ld_entry(ld_entry), .rq_valid(rq_valid),
    .rq_ready(rq_ready), .rq_cyl(rq_cyl), .rq_head(rq_head), .rq_sector(rq_sector),
    .rq_reject(rq_reject), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_last(out_last), .busy(busy));

  dlr_ctl_model mdl (.clock(clock), .resetn(resetn), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready), .hold(hold));

  // Free-running bench clock of 50 ns.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the result.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Cuts a hang short.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end

  // Works out the expected field for one surface.
  function automatic void build(input logic [2:0] h);
    int k = 0;
    for (int i = 0; i < 256; i++) exp_f[i] = DLR_PAD_BYTE;
    foreach (q_ent[j]) begin
      if (q_head[j] == h) begin
        for (int b = 0; b < 5; b++) exp_f[k + b] = q_ent[j][39 - 8 * b -: 8];
        k += 5;
      end
    end
    for (int b = 0; b < 5; b++) exp_f[k + b] = DLR_MARK_BYTE;
  endfunction : build

  // Offers one entry and holds it until it is taken.
  task automatic load(input logic [2:0] h, input logic [39:0] e);
    ld_head = h;
    ld_entry = e;
    ld_valid = 1'b1;
    while (ld_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    ld_valid = 1'b0;
    q_head.push_back(h);
    q_ent.push_back(e);
    // Let one edge pass with valid low before the next offer.
    @(negedge clock);
  endtask : load

  // Makes one sector request and checks its answer and, on a hit, the whole stream.
  task automatic req(input logic [10:0] c, input logic [2:0] h, input logic [7:0] s,
                     input logic hit);
    int f;
    f = mdl.frames;
    rq_cyl = c;
    rq_head = h;
    rq_sector = s;
    rq_valid = 1'b1;
    while (rq_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    rq_valid = 1'b0;
    chk(16'(rq_reject), 16'(!hit));
    chk(16'(busy), 16'(hit));
    @(negedge clock);
    chk(16'(rq_reject), 16'h0000);
    if (hit && hold) begin
      repeat (100) @(negedge clock);
      chk(16'({busy, rq_ready, ld_ready, out_valid, out_data}), 16'h09A1);
      hold = 1'b0;
    end
    if (hit) begin
      build(h);
      for (int i = 0; i < 5000 && mdl.frames == f; i++) @(negedge clock);
      chk(16'(mdl.frames), 16'(f + 1));
      chk(16'(mdl.last_n), 16'd259);
      chk(16'(mdl.mem[0]), 16'(DLR_SYNC_BYTE));
      for (int i = 0; i < 256; i++) chk(16'(mdl.mem[i + 1]), 16'(exp_f[i]));
      chk(16'({mdl.crc_ok, mdl.crc_err}), 16'h0002);
    end
  endtask : req

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {ld_clear, ld_valid, rq_valid, hold} = 4'h0;
    {ld_head, ld_entry, rq_cyl, rq_head, rq_sector} = '0;
    resetn = 1'b0;
    n_fail = 0;
    total_checks = 0;
    cyc = 0;
    void'($urandom(32'h86d96bd2));
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    chk(16'({ld_ready, rq_ready, busy, out_valid}), 16'h000C);
    // Fill the store with random entries on four surfaces until it refuses.
    for (int i = 0; i < 16; i++) load(3'($urandom_range(0, 3)), 40'({$urandom, $urandom}));
    chk(16'(ld_ready), 16'h0000);
    for (int h = 0; h < 4; h++) req(DLR_PRIMARY_CYL, 3'(h), DLR_LIST_SECTOR, 1'b1);
    // Backup copy, with the reader stalling until the buffer fills.
    hold = 1'b1;
    req(DLR_BACKUP_CYL, 3'h2, DLR_LIST_SECTOR, 1'b1);
    for (int i = 0; i < 4; i++) req(miss_tbl[i][18:8], 3'(i), miss_tbl[i][7:0], 1'b0);
    // Empty the store; a surface then shows only the end marker.
    @(negedge clock);
    ld_clear = 1'b1;
    @(negedge clock);
    chk(16'(ld_ready), 16'h0000);
    ld_clear = 1'b0;
    q_head.delete();
    q_ent.delete();
    @(negedge clock);
    chk(16'(ld_ready), 16'h0001);
    req(DLR_PRIMARY_CYL, 3'h5, DLR_LIST_SECTOR, 1'b1);
    load(3'h7, 40'h00_1234_5678);
    load(3'h7, 40'hFF_FFFF_FFFE);
    req(DLR_PRIMARY_CYL, 3'h7, DLR_LIST_SECTOR, 1'b1);
    summarize();
  end
endmodule : tb_top
